// ===== verilog/tcep_pkg.sv
// Behaviour
// - Edge divider captures every 1, 2, 4, 8 edges.
// - Clearing enable clears the edge divider count.
// - Control register holds enable, polarity, comp polarity per channel.
// - Output polarity bit zero gives an active-high output; one holds the output low.
// - Polarity pair selects rising, falling or both edges.
// - Polarity writes ignored while protection is 11 or 10.
// - Enable drives output active or allows capture.
// - Counter reads current count; writes load it immediately.
// - Control register accepts half-word and word accesses.
// - Input filter needs N equal samples; zero bypasses.
// - Mode select zero is output, otherwise input.
package tcep_pkg;

  localparam int TCEP_NCH = 4;
  localparam logic [7:0] TCEP_OFS_CHCTL = 8'h20;
  localparam logic [7:0] TCEP_OFS_COUNT = 8'h24;
  localparam logic [31:0] TCEP_RESET_VAL = 32'h0000_0000;
  localparam logic [15:0] TCEP_CTL_USED_MASK = 16'hBBBB;
  localparam logic [15:0] TCEP_POL_MASK = 16'hAAAA;
  localparam int TCEP_EN_BIT = 0;
  localparam int TCEP_POL_BIT = 1;
  localparam int TCEP_NPOL_BIT = 3;
  localparam int TCEP_CH_STRIDE = 4;
  localparam logic [1:0] TCEP_MODE_OUTPUT = 2'h0;
  localparam logic [1:0] TCEP_PROTECTION_LEVEL_HI = 2'h2;
  localparam logic [1:0] TCEP_EDGE_RISE = 2'h0;
  localparam logic [1:0] TCEP_EDGE_FALL = 2'h1;
  localparam logic [1:0] TCEP_EDGE_BOTH = 2'h3;
  localparam logic [3:0] TCEP_FLT_OFF = 4'h0;
  localparam logic [3:0] TCEP_FLT_MAX = 4'h7;

  // One register-bus request as seen by the block.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } tcep_req_t;

  // Per-channel input configuration.
  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] filter;
    logic [1:0] divider;
  } tcep_chcfg_t;

endpackage : tcep_pkg

// ===== verilog/tcep_channel.sv
`timescale 1ns/1ps
module tcep_channel
  import tcep_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic in_i,
  input wire tcep_chcfg_t cfg_i,
  input wire logic enable_i,
  input wire logic polarity_i,
  input wire logic comp_polarity_i,
  input wire logic [15:0] count_i,
  output logic active_o,
  output logic capture_o,
  output logic [15:0] value_o
);

  logic [3:0] run_reg, run_next;
  logic [2:0] div_reg, div_next;
  logic [2:0] smp_reg, smp_next;
  logic filt_reg, filt_next;
  logic prev_reg, prev_next;
  logic cap_reg, cap_next;
  logic [15:0] value_reg, value_next;
  logic [3:0] need;
  logic samp_en;
  logic raw_level;
  logic edge_hit;
  logic [2:0] div_last;

  // Number of equal samples and sample rate; codes above seven fall back to bypass.
  always_comb
  begin
    need = 4'h0;
    samp_en = 1'b1;
    case (cfg_i.filter)
      4'h1: need = 4'h2;
      4'h2: need = 4'h4;
      4'h3: need = 4'h8;
      4'h4:
      begin
        need = 4'h6;
        samp_en = smp_reg[0];
      end
      4'h5:
      begin
        need = 4'h8;
        samp_en = smp_reg[0];
      end
      4'h6:
      begin
        need = 4'h6;
        samp_en = &smp_reg[1:0];
      end
      4'h7:
      begin
        need = 4'h8;
        samp_en = &smp_reg[1:0];
      end
      default: need = 4'h0;
    endcase
    case (cfg_i.divider)
      2'h0: div_last = 3'h0;
      2'h1: div_last = 3'h1;
      2'h2: div_last = 3'h3;
      default: div_last = 3'h7;
    endcase
  end

  // Filter, edge selection, edge divider and capture latch.
  always_comb
  begin
    smp_next = smp_reg + 3'h1;
    run_next = run_reg;
    filt_next = filt_reg;
    if (cfg_i.filter == TCEP_FLT_OFF || cfg_i.filter > TCEP_FLT_MAX)
    begin
      filt_next = in_i;
      run_next = 4'h0;
    end
    else if (samp_en)
    begin
      if (in_i == filt_reg)
        run_next = 4'h0;
      else if (run_reg + 4'h1 >= need)
      begin
        filt_next = in_i;
        run_next = 4'h0;
      end
      else
        run_next = run_reg + 4'h1;
    end
    raw_level = filt_reg ^ polarity_i; // Inverted when falling or both edges are chosen.
    prev_next = raw_level;
    case ({comp_polarity_i, polarity_i})
      TCEP_EDGE_RISE: edge_hit = raw_level & ~prev_reg;
      TCEP_EDGE_FALL: edge_hit = raw_level & ~prev_reg;
      TCEP_EDGE_BOTH: edge_hit = filt_reg ^ (prev_reg ^ polarity_i);
      default: edge_hit = 1'b0; // Reserved code never captures.
    endcase
    div_next = div_reg;
    cap_next = 1'b0;
    value_next = value_reg;
    if (!enable_i)
      div_next = 3'h0;
    else if (cfg_i.mode != TCEP_MODE_OUTPUT && edge_hit)
    begin
      if (div_reg >= div_last)
      begin
        div_next = 3'h0;
        cap_next = 1'b1;
        value_next = count_i;
      end
      else
        div_next = div_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      run_reg <= 4'h0;
      div_reg <= 3'h0;
      smp_reg <= 3'h0;
      filt_reg <= 1'b0;
      prev_reg <= 1'b0;
      cap_reg <= 1'b0;
      value_reg <= 16'h0000;
    end
    else
    begin
      run_reg <= run_next;
      div_reg <= div_next;
      smp_reg <= smp_next;
      filt_reg <= filt_next;
      prev_reg <= prev_next;
      cap_reg <= cap_next;
      value_reg <= value_next;
    end
  end

  // Output stage: an enabled output-mode channel drives one; polarity one holds it at zero.
  assign active_o = (cfg_i.mode == TCEP_MODE_OUTPUT) & enable_i & ~polarity_i;
  assign capture_o = cap_reg;
  assign value_o = value_reg;

endmodule : tcep_channel

// ===== verilog/tcep_timer_channels.sv
`timescale 1ns/1ps
module tcep_timer_channels
  import tcep_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire tcep_req_t req_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  input wire logic [1:0] protection_level_i,
  input wire logic count_en_i,
  input wire logic [TCEP_NCH-1:0] filtered_edge_input_i,
  input wire tcep_chcfg_t [TCEP_NCH-1:0] chan_cfg_i,
  output logic [TCEP_NCH-1:0] chan_out_o,
  output logic [TCEP_NCH-1:0] capture_o,
  output logic [TCEP_NCH*16-1:0] capture_value_o
);

  logic [15:0] ctl_reg, ctl_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [31:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [15:0] wmask;
  logic [15:0] wr_ctl;
  logic [TCEP_NCH-1:0] active;

  // Register writes; upper half of the control word is reserved and stays zero.
  always_comb
  begin
    ctl_next = ctl_reg;
    cnt_next = count_en_i ? cnt_reg + 16'h0001 : cnt_reg;
    wmask = {{8{req_i.be[1]}}, {8{req_i.be[0]}}} & TCEP_CTL_USED_MASK;
    if (protection_level_i >= TCEP_PROTECTION_LEVEL_HI)
      wmask = wmask & ~TCEP_POL_MASK;
    wr_ctl = (ctl_reg & ~wmask) | (req_i.wdata[15:0] & wmask);
    if (req_i.wr && req_i.addr == TCEP_OFS_CHCTL)
      ctl_next = wr_ctl;
    if (req_i.wr && req_i.addr == TCEP_OFS_COUNT)
      cnt_next = req_i.wdata[15:0]; // Write takes precedence over counting.
    rvalid_next = req_i.rd;
    rdata_next = TCEP_RESET_VAL;
    if (req_i.rd)
    begin
      case (req_i.addr)
        TCEP_OFS_CHCTL: rdata_next = {16'h0000, ctl_reg};
        TCEP_OFS_COUNT: rdata_next = {16'h0000, cnt_reg};
        default: rdata_next = TCEP_RESET_VAL;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ctl_reg <= TCEP_RESET_VAL[15:0];
      cnt_reg <= TCEP_RESET_VAL[15:0];
      rdata_reg <= TCEP_RESET_VAL;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      ctl_reg <= ctl_next;
      cnt_reg <= cnt_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // One channel instance per capture/compare channel.
  for (genvar n = 0; n < TCEP_NCH; n++)
  begin : g_ch
    tcep_channel u_ch (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .in_i(filtered_edge_input_i[n]),
      .cfg_i(chan_cfg_i[n]),
      .enable_i(ctl_reg[n*TCEP_CH_STRIDE+TCEP_EN_BIT]),
      .polarity_i(ctl_reg[n*TCEP_CH_STRIDE+TCEP_POL_BIT]),
      .comp_polarity_i(ctl_reg[n*TCEP_CH_STRIDE+TCEP_NPOL_BIT]),
      .count_i(cnt_reg),
      .active_o(active[n]),
      .capture_o(capture_o[n]),
      .value_o(capture_value_o[n*16 +: 16])
    );
  end

  assign chan_out_o = active;
  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;

endmodule : tcep_timer_channels

// ===== tb/tcep_chk.sv
`timescale 1ns/1ps
module tcep_chk
  import tcep_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire tcep_req_t req_i,
  input wire logic [31:0] rdata_o,
  input wire logic rvalid_o,
  input wire tcep_chcfg_t [3:0] chan_cfg_i,
  input wire logic [3:0] chan_out_o,
  input wire logic [3:0] capture_o,
  input wire logic [63:0] capture_value_o
);
  // One clock domain, so clocking and reset masking are set once.
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_ans; req_i.rd |=> rvalid_o; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_src; rvalid_o |-> $past(req_i.rd); endproperty
  a_src: assert property (p_src) else $error("stray answer");
  property p_idle; !rvalid_o |-> rdata_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data outside answer");
  property p_cnt; req_i.rd && req_i.addr == 8'h24 |=> rdata_o[31:16] == 16'h0; endproperty
  a_cnt: assert property (p_cnt) else $error("counter top half set");
  property p_rsv; req_i.rd && req_i.addr == 8'h20 |=> (rdata_o & 32'hFFFF4444) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_unm; req_i.rd && req_i.addr != 8'h20 && req_i.addr != 8'h24 |=> rdata_o == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_val; $changed(capture_value_o[15:0]) |-> capture_o[0]; endproperty
  a_val: assert property (p_val) else $error("value moved without capture");
  property p_out; chan_out_o[0] |-> chan_cfg_i[0].mode == 2'h0; endproperty
  a_out: assert property (p_out) else $error("output active in input mode");
endmodule : tcep_chk
bind tcep_timer_channels tcep_chk u_chk (.clk_sys_i, .rst_i, .req_i, .rdata_o, .rvalid_o, .chan_cfg_i,
  .chan_out_o, .capture_o, .capture_value_o);

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb
  import tcep_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  tcep_req_t req = '0;
  logic [1:0] protection_level = 2'h0;
  logic cen = 1'b0;
  logic [3:0] fin = 4'h0;
  tcep_chcfg_t [3:0] cfg = '0;
  logic [31:0] rdata;
  logic rvalid;
  logic [3:0] cout;
  logic [3:0] cap;
  logic [63:0] cval;
  int err_total = 0;
  int num_checks = 0;
  int caps = 0;
  // Free-running 50 MHz clock.
  always #10 clk_sys_i = ~clk_sys_i;
  // Channel 0 captures are tallied so scenarios can count them.
  always @(posedge clk_sys_i)
    if (cap[0] === 1'b1)
      caps <= caps + 1;
  tcep_timer_channels uut (.clk_sys_i, .rst_i, .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .protection_level_i(protection_level),
    .count_en_i(cen), .filtered_edge_input_i(fin), .chan_cfg_i(cfg), .chan_out_o(cout), .capture_o(cap),
    .capture_value_o(cval));
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask : chk
  // Requests stand for one edge; an idle cycle follows so nothing is driven twice at once.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF);
    req = {2'b10, a, b, d};
    @(negedge clk_sys_i);
    req = '0;
    @(negedge clk_sys_i);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    req = {2'b01, a, 4'hF, 32'h0};
    @(negedge clk_sys_i);
    req = '0;
    // The answer stands for one cycle only, so it is judged before the next edge clears it.
    chk(rdata, e);
    chk({31'h0, rvalid}, 32'h1);
    @(negedge clk_sys_i);
  endtask : rd
  task pulses(input int n);
    repeat (n)
    begin
      fin[0] = 1'b1;
      repeat (5) @(negedge clk_sys_i);
      fin[0] = 1'b0;
      repeat (5) @(negedge clk_sys_i);
    end
  endtask : pulses
  // Reserved bits, byte writes, the polarity lock and output levels.
  task t_regs;
    rd(8'h20, 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'hBBBB);
    wr(8'h20, 32'h0, 4'h1);
    rd(8'h20, 32'hBB00);
    protection_level = 2'h3;
    wr(8'h20, 32'h0);
    rd(8'h20, 32'hAA00);
    protection_level = 2'h2;
    wr(8'h20, 32'hFFFF);
    rd(8'h20, 32'hBB11);
    protection_level = 2'h1;
    wr(8'h20, 32'h131);
    chk({28'h0, cout}, 32'h5);
    wr(8'h44, 32'hFFFF);
    rd(8'h44, 32'h0);
    wr(8'h20, 32'h0);
  endtask : t_regs
  // A counter write takes effect at once and counting resumes from it.
  task t_count;
    rd(8'h24, 32'h0);
    wr(8'h24, 32'hABCD1234);
    rd(8'h24, 32'h1234);
    cen = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    cen = 1'b0;
    rd(8'h24, 32'h1239);
  endtask : t_count
  // Every edge code and divider; the divider count left by three pulses before a disable must be forgotten.
  task t_capture;
    logic [31:0] p;
    int c0;
    int per;
    for (int e = 0; e < 4; e++)
      for (int d = 0; d < 4; d++)
      begin
        p = {28'h0, e[1], 1'b0, e[0], 1'b0};
        per = (e == 3) ? 2 : (e == 2) ? 0 : 1;
        c0 = caps;
        wr(8'h20, p);
        cfg[0] = {2'h1, 4'h0, d[1:0]};
        wr(8'h20, p | 32'h1);
        pulses(3);
        wr(8'h20, p);
        wr(8'h20, p | 32'h1);
        pulses(5);
        chk(caps - c0, ((3 * per) >> d) + ((5 * per) >> d));
      end
    chk({16'h0, cval[15:0]}, 32'h1239);
  endtask : t_capture
  // A one-cycle glitch and a pulse shorter than the sample count must both be swallowed.
  task t_filter;
    int c0;
    wr(8'h20, 32'h0);
    cfg[0] = {2'h1, 4'h1, 2'h0};
    wr(8'h20, 32'h1);
    c0 = caps;
    fin[0] = 1'b1;
    @(negedge clk_sys_i);
    fin[0] = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    chk(caps - c0, 32'h0);
    pulses(1);
    chk(caps - c0, 32'h1);
    cfg[0].filter = 4'h3;
    pulses(1);
    chk(caps - c0, 32'h1);
  endtask : t_filter
  task finish_test;
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // Reset for 12 cycles, then each scenario in turn.
  initial
  begin
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    t_regs();
    t_count();
    t_capture();
    t_filter();
    finish_test();
  end
endmodule : tb
